// file: shared/pdc_pkg.sv
// Package: constants for the power-down control block
package pdc_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h1;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// ==========================================================
	// Control register fields
	localparam int DIG_PD_POS = 7;
	localparam int PLL_PD_POS = 6;
	localparam int DAC_PD_POS = 5;
	localparam int CLK_PD_POS = 4;
	localparam int MODE_POS = 3;
	localparam int CTRL_LSB = 3;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

	// ==========================================================
	// Status register fields
	localparam int ST_EXT_POS = 0;
	localparam int ST_FULL_POS = 1;
	localparam int ST_FAST_POS = 2;
	localparam int ST_CLK_POS = 4;
	localparam int ST_DAC_POS = 5;
	localparam int ST_PLL_POS = 6;
	localparam int ST_DIG_POS = 7;

	// ==========================================================
	// Values after reset
	localparam logic PD_RST = 1'b0;
	localparam logic [7:0] RD_RST = 8'h00;

endpackage

// file: shared/pdc_pd_if.sv
// Interface: decoded power-down controls between decoder and top
interface pdc_pd_if;
	logic digital_pd;
	logic pll_pd;
	logic dac_pd;
	logic input_clock_pd;
	logic ext_active;
	logic full_active;
	logic fast_active;

	modport src (
		output digital_pd,
		output pll_pd,
		output dac_pd,
		output input_clock_pd,
		output ext_active,
		output full_active,
		output fast_active
	);
	modport dst (
		input digital_pd,
		input pll_pd,
		input dac_pd,
		input input_clock_pd,
		input ext_active,
		input full_active,
		input fast_active
	);
endinterface

// file: logic/pdc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
module pdc_sync #(
	parameter int WIDTH = 1
) (
	input logic i_clk_sys,
	input logic i_sys_rst,
	input logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ==========================================================
	// Parameter check
	if (WIDTH < 1) begin : g_chk
		$error("pdc_sync: WIDTH must be at least 1");
	end

	// ==========================================================
	// One pair of flops per bit; stage one feeds only stage two
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge i_clk_sys) begin
			if (i_sys_rst) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= i_async[g];
				sync_q <= meta_q;
			end
		end
		assign o_sync[g] = sync_q;
	end

endmodule

// file: logic/pdc_decode.sv
// Combinational power-down decoder for the four power domains
module pdc_decode (
	input logic i_ext_pd,
	input logic [pdc_pkg::CTRL_W-1:0] i_ctrl,
	pdc_pd_if.src pd
);

	logic mode_full;
	logic dig_bit;
	logic pll_bit;
	logic dac_bit;
	logic clk_bit;

	assign mode_full = i_ctrl[pdc_pkg::MODE_POS-pdc_pkg::CTRL_LSB];
	assign dig_bit = i_ctrl[pdc_pkg::DIG_PD_POS-pdc_pkg::CTRL_LSB];
	assign pll_bit = i_ctrl[pdc_pkg::PLL_PD_POS-pdc_pkg::CTRL_LSB];
	assign dac_bit = i_ctrl[pdc_pkg::DAC_PD_POS-pdc_pkg::CTRL_LSB];
	assign clk_bit = i_ctrl[pdc_pkg::CLK_PD_POS-pdc_pkg::CTRL_LSB];

	// ==========================================================
	// Mode selection; a 1 always means low power
	always_comb begin
		pd.ext_active = i_ext_pd;
		pd.full_active = i_ext_pd & mode_full;
		pd.fast_active = i_ext_pd & ~mode_full;
		if (!i_ext_pd) begin
			// Software control, mode bit ignored
			pd.digital_pd = dig_bit;
			pd.dac_pd = dac_bit;
			pd.input_clock_pd = clk_bit;
			pd.pll_pd = pll_bit;
		end else if (mode_full) begin
			// Everything off; PLL and DAC are slow to return
			pd.digital_pd = 1'b1;
			pd.dac_pd = 1'b1;
			pd.input_clock_pd = 1'b1;
			pd.pll_pd = 1'b1;
		end else begin
			// Keep clocks and bias alive for quick wake-up
			pd.digital_pd = 1'b1;
			pd.dac_pd = 1'b0;
			pd.input_clock_pd = 1'b0;
			pd.pll_pd = pll_bit;
		end
	end

endmodule

// file: logic/pdc_top.sv
// Top: power-down control with register port and pin synchroniser
//
// Function
// - Four software bits in the control register power down the DAC, PLL, input clock and digital logic separately.
// - While the external pin is high the software bits are ignored, except the PLL bit which acts in fast-recovery mode only.
// - While the external pin is high the block enters a power-down mode chosen by the mode-select bit.
// - While the external pin is low external control is off and the software bits decide.
// - Mode bit 0 with the pin high gives fast-recovery power-down of the digital logic only.
// - In fast-recovery mode the DAC bias, oscillator and clock input stay powered; the PLL follows its software bit.
// - Mode bit 1 with the pin high powers down everything, DAC and PLL included.
// - With the pin high the digital, DAC and input-clock software bits are don't-care.
// - Every power-down bit and signal uses 1 for low power and 0 for active.
// - Under software control digital, DAC and input-clock power-down follow bits 7, 5 and 4.
// - Fast-recovery drives digital at 1 and DAC and input clock at 0.
// - Full power-down drives digital, DAC and input clock all at 1.
module pdc_top #(
	parameter int ADDR_W = pdc_pkg::ADDR_W,
	parameter int DATA_W = pdc_pkg::DATA_W
) (
	input logic i_clk_sys,
	input logic i_sys_rst,
	input logic i_ext_power_down_in,
	input logic [ADDR_W-1:0] i_addr,
	input logic [DATA_W-1:0] i_wr_data,
	input logic i_wr_stb,
	input logic i_rd_stb,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_digital_pd,
	output logic o_pll_pd,
	output logic o_dac_pd,
	output logic o_input_clock_pd,
	output logic o_ext_pd_active,
	output logic o_full_pd_active
);

	// ==========================================================
	// Parameter check
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_addr
		$error("pdc_top: ADDR_W out of range");
	end
	if (DATA_W < 8) begin : g_chk_data
		$error("pdc_top: DATA_W must be at least 8");
	end

	// ==========================================================
	// Declarations
	localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'(pdc_pkg::CTRL_OFS);
	localparam logic [ADDR_W-1:0] STAT_A = ADDR_W'(pdc_pkg::STAT_OFS);

	logic [pdc_pkg::CTRL_W-1:0] ctrl_q;
	logic [pdc_pkg::CTRL_W-1:0] ctrl_d;
	logic ext_s;
	logic fast_q;
	logic [7:0] stat_byte;
	logic [7:0] rd_byte;
	logic [DATA_W-1:0] rd_d;

	pdc_pd_if pd_bus ();

	// ==========================================================
	// Pin synchroniser
	pdc_sync #(
		.WIDTH(1)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_async(i_ext_power_down_in),
		.o_sync(ext_s)
	);

	// ==========================================================
	// Decoder
	pdc_decode u_decode (
		.i_ext_pd(ext_s),
		.i_ctrl(ctrl_q),
		.pd(pd_bus)
	);

	// ==========================================================
	// Control register; only bits 7:3 are stored here
	always_comb begin
		ctrl_d = ctrl_q;
		if (i_wr_stb && i_addr == CTRL_A) begin
			ctrl_d = i_wr_data[pdc_pkg::CTRL_LSB +: pdc_pkg::CTRL_W];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ctrl_q <= pdc_pkg::CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ==========================================================
	// Registered power-down outputs
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_digital_pd <= pdc_pkg::PD_RST;
			o_pll_pd <= pdc_pkg::PD_RST;
			o_dac_pd <= pdc_pkg::PD_RST;
			o_input_clock_pd <= pdc_pkg::PD_RST;
		end else begin
			o_digital_pd <= pd_bus.digital_pd;
			o_pll_pd <= pd_bus.pll_pd;
			o_dac_pd <= pd_bus.dac_pd;
			o_input_clock_pd <= pd_bus.input_clock_pd;
		end
	end

	// ==========================================================
	// Mode indicators
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_ext_pd_active <= 1'b0;
			o_full_pd_active <= 1'b0;
			fast_q <= 1'b0;
		end else begin
			o_ext_pd_active <= pd_bus.ext_active;
			o_full_pd_active <= pd_bus.full_active;
			fast_q <= pd_bus.fast_active;
		end
	end

	// ==========================================================
	// Read path; status shows what the domains actually receive
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[pdc_pkg::ST_EXT_POS] = o_ext_pd_active;
		stat_byte[pdc_pkg::ST_FULL_POS] = o_full_pd_active;
		stat_byte[pdc_pkg::ST_FAST_POS] = fast_q;
		stat_byte[pdc_pkg::ST_CLK_POS] = o_input_clock_pd;
		stat_byte[pdc_pkg::ST_DAC_POS] = o_dac_pd;
		stat_byte[pdc_pkg::ST_PLL_POS] = o_pll_pd;
		stat_byte[pdc_pkg::ST_DIG_POS] = o_digital_pd;
		rd_byte = 8'h00;
		if (i_addr == CTRL_A) begin
			rd_byte[pdc_pkg::CTRL_LSB +: pdc_pkg::CTRL_W] = ctrl_q;
		end else if (i_addr == STAT_A) begin
			rd_byte = stat_byte;
		end
		rd_d = '0;
		if (i_rd_stb) begin
			rd_d[7:0] = rd_byte;
		end
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rd_data <= DATA_W'(pdc_pkg::RD_RST);
		end else begin
			o_rd_data <= rd_d;
		end
	end

	// ==========================================================
	// Assertions
	localparam int DIG_I = pdc_pkg::DIG_PD_POS - pdc_pkg::CTRL_LSB;
	localparam int PLL_I = pdc_pkg::PLL_PD_POS - pdc_pkg::CTRL_LSB;
	localparam int DAC_I = pdc_pkg::DAC_PD_POS - pdc_pkg::CTRL_LSB;
	localparam int CLK_I = pdc_pkg::CLK_PD_POS - pdc_pkg::CTRL_LSB;
	localparam int MODE_I = pdc_pkg::MODE_POS - pdc_pkg::CTRL_LSB;

	sequence ctrl_wr_s;
		i_wr_stb && i_addr == CTRL_A;
	endsequence

	sequence ctrl_rd_s;
		i_rd_stb && i_addr == CTRL_A;
	endsequence

	sequence pin_high_s;
		i_ext_power_down_in [*3];
	endsequence

	sw_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!ext_s |=> o_digital_pd == $past(ctrl_q[DIG_I]) &&
			o_dac_pd == $past(ctrl_q[DAC_I]) &&
			o_input_clock_pd == $past(ctrl_q[CLK_I]))
		else $error("software power-down not followed");

	fast_rec_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ext_s && !ctrl_q[MODE_I] |=> o_digital_pd && !o_dac_pd &&
			!o_input_clock_pd)
		else $error("fast-recovery levels wrong");

	fast_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ext_s && !ctrl_q[MODE_I] && !ctrl_q[PLL_I] |=>
			!o_pll_pd && !o_input_clock_pd && !o_full_pd_active)
		else $error("fast-recovery powered down a kept domain");

	full_pd_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ext_s && ctrl_q[MODE_I] |=> o_digital_pd && o_dac_pd &&
			o_input_clock_pd && o_pll_pd && o_full_pd_active)
		else $error("full power-down incomplete");

	pll_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!(ext_s && ctrl_q[MODE_I]) |=> o_pll_pd == $past(ctrl_q[PLL_I]))
		else $error("PLL bit lost its effect");

	bits_ignored_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ext_s ##1 ext_s && $changed(ctrl_q) && $stable(ctrl_q[MODE_I]) &&
			$stable(ctrl_q[PLL_I]) |=> $stable({o_digital_pd, o_dac_pd,
			o_input_clock_pd, o_pll_pd}))
		else $error("software bits acted under external control");

	pin_entry_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		pin_high_s |=> o_ext_pd_active && o_digital_pd)
		else $error("pin high did not enter power-down");

	pin_exit_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_ext_power_down_in [*3] |=> !o_ext_pd_active && !o_full_pd_active &&
			!fast_q)
		else $error("external control active with pin low");

	active_low_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!ext_s && ctrl_q == '0 |=> !o_digital_pd && !o_pll_pd &&
			!o_dac_pd && !o_input_clock_pd)
		else $error("zero bits did not give active state");

	ctrl_rdback_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ctrl_wr_s ##1 ctrl_rd_s |=> o_rd_data[pdc_pkg::CTRL_LSB +:
			pdc_pkg::CTRL_W] == $past(i_wr_data[pdc_pkg::CTRL_LSB +:
			pdc_pkg::CTRL_W], 2))
		else $error("control register readback wrong");

	mode_pick_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ext_s |=> o_full_pd_active == $past(ctrl_q[MODE_I]) &&
			fast_q == !$past(ctrl_q[MODE_I]))
		else $error("mode select not honoured");

	// ==========================================================
	// Pin timing and register port checks
	sequence pin_rise_s;
		!i_ext_power_down_in ##1 i_ext_power_down_in [*3];
	endsequence

	sequence pin_fall_s;
		i_ext_power_down_in ##1 !i_ext_power_down_in [*3];
	endsequence

	pin_rise_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		pin_rise_s |=> $rose(o_ext_pd_active))
		else $error("external control late or early after pin rise");

	pin_fall_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		pin_fall_s |=> $fell(o_ext_pd_active))
		else $error("external control late or early after pin fall");

	rd_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_rd_stb |=> o_rd_data == '0)
		else $error("read data present without a read");

	unmapped_rd_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_rd_stb && i_addr != CTRL_A && i_addr != STAT_A |=>
			o_rd_data == '0)
		else $error("unmapped read returned data");

	ctrl_load_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		ctrl_wr_s |=> ctrl_q == $past(i_wr_data[pdc_pkg::CTRL_LSB +:
			pdc_pkg::CTRL_W]))
		else $error("control write not stored");

	ctrl_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!(i_wr_stb && i_addr == CTRL_A) |=> $stable(ctrl_q))
		else $error("control register changed without a write");

	// Status shows the flopped outputs, so software sees what the domains see
	stat_rd_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_rd_stb && i_addr == STAT_A |=>
			o_rd_data[pdc_pkg::ST_EXT_POS] == $past(o_ext_pd_active) &&
			o_rd_data[pdc_pkg::ST_FULL_POS] == $past(o_full_pd_active) &&
			o_rd_data[pdc_pkg::ST_FAST_POS] == $past(fast_q) &&
			o_rd_data[pdc_pkg::ST_DIG_POS] == $past(o_digital_pd) &&
			o_rd_data[pdc_pkg::ST_DAC_POS] == $past(o_dac_pd) &&
			o_rd_data[pdc_pkg::ST_CLK_POS] == $past(o_input_clock_pd) &&
			o_rd_data[pdc_pkg::ST_PLL_POS] == $past(o_pll_pd))
		else $error("status readback wrong");

	fast_out_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		fast_q |-> o_digital_pd && !o_dac_pd && !o_input_clock_pd)
		else $error("fast-recovery outputs inconsistent");

	fast_pll_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		fast_q |-> o_pll_pd == $past(ctrl_q[PLL_I]))
		else $error("PLL bit ignored in fast-recovery");

	full_out_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_full_pd_active |-> o_digital_pd && o_dac_pd && o_input_clock_pd &&
			o_pll_pd)
		else $error("full power-down outputs inconsistent");

	rst_vals_a: assert property (@(posedge i_clk_sys)
		$fell(i_sys_rst) |-> ctrl_q == pdc_pkg::CTRL_RST && !o_digital_pd &&
			!o_pll_pd && !o_dac_pd && !o_input_clock_pd && !o_ext_pd_active &&
			!o_full_pd_active && o_rd_data == '0)
		else $error("state after reset not idle");

endmodule

// file: dv/pdc_ctl_model.sv
// Model of the system controller that drives the external power-down pin
module pdc_ctl_model (
	input wire logic i_clk_sys,
	output logic o_ext_power_down_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Pin driver
	// Pin starts low so the mode bit can be set before any power-down
	initial begin
		o_ext_power_down_in = 1'b0;
	end

	// Pin moves just after an edge; the block syncs it anyway
	// Callers set the mode bit while the pin is still low
	task automatic set_pin(input logic lvl);
		@(posedge i_clk_sys);
		o_ext_power_down_in <= lvl;
	endtask
endmodule

// file: dv/test_power_down_control.sv
// Testbench: register port and power-down decoding of the block
`define CHK(nm, ex, gt) begin \
	num_checks++; \
	if ((gt) !== (ex)) begin \
		error_cnt++; \
		$display("Error %s exp %h got %h", nm, ex, gt); \
	end \
end

module test_power_down_control;
	timeunit 1ns;
	timeprecision 1ns;

	logic i_clk_sys, i_sys_rst, pin, wr_stb, rd_stb;
	logic [3:0] addr;
	logic [7:0] wdata, rd_data, v, got;
	logic dig, pll, dac, clk_pd, ext, full;
	logic [5:0] exp_o;
	int error_cnt, num_checks;

	// ==========================================================
	// Instances
	pdc_top dut_u (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ext_power_down_in(pin),
		.i_addr(addr),
		.i_wr_data(wdata),
		.i_wr_stb(wr_stb),
		.i_rd_stb(rd_stb),
		.o_rd_data(rd_data),
		.o_digital_pd(dig),
		.o_pll_pd(pll),
		.o_dac_pd(dac),
		.o_input_clock_pd(clk_pd),
		.o_ext_pd_active(ext),
		.o_full_pd_active(full)
	);

	pdc_ctl_model ctl_u (
		.i_clk_sys(i_clk_sys),
		.o_ext_power_down_in(pin)
	);

	// ==========================================================
	// Clock, reset and bus tasks
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	// Called right after a rising edge, so a read may follow with no gap
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge i_clk_sys);
		wr_stb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge i_clk_sys);
		rd_stb <= 1'b0;
		@(negedge i_clk_sys);
		d = rd_data;
		@(posedge i_clk_sys);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		i_sys_rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		repeat (4) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		rd(pdc_pkg::CTRL_OFS, got);
		`CHK("ctrl reset", 8'h00, got)
		`CHK("outs reset", 6'h00, {dig, pll, dac, clk_pd, ext, full})
		// Every control value under each pin level
		for (int i = 0; i < 32; i++) begin
			for (int p = 0; p < 2; p++) begin
				v = 8'(i << 3);
				ctl_u.set_pin(1'b0);
				repeat (4) @(posedge i_clk_sys);
				wr(pdc_pkg::CTRL_OFS, v);
				rd(pdc_pkg::CTRL_OFS, got);
				`CHK("ctrl", v, got)
				ctl_u.set_pin(p[0]);
				repeat (4) @(posedge i_clk_sys);
				@(negedge i_clk_sys);
				if (p == 0) begin
					exp_o = {v[7], v[6], v[5], v[4], 2'b00};
				end else if (!v[3]) begin
					exp_o = {1'b1, v[6], 2'b00, 2'b10};
				end else begin
					exp_o = 6'h3f;
				end
				`CHK("outs", exp_o, {dig, pll, dac, clk_pd, ext, full})
				@(posedge i_clk_sys);
				rd(pdc_pkg::STAT_OFS, got);
				`CHK("status", {exp_o[5:2], 1'b0, p[0] & ~v[3], exp_o[0], exp_o[1]}, got)
			end
		end
		// Software bits written while the pin holds control
		wr(pdc_pkg::CTRL_OFS, 8'h48);
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		`CHK("full kept", 6'h3f, {dig, pll, dac, clk_pd, ext, full})
		ctl_u.set_pin(1'b0);
		repeat (4) @(posedge i_clk_sys);
		wr(pdc_pkg::CTRL_OFS, 8'h40);
		ctl_u.set_pin(1'b1);
		repeat (4) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		`CHK("fast pll on", 6'h32, {dig, pll, dac, clk_pd, ext, full})
		@(posedge i_clk_sys);
		wr(pdc_pkg::CTRL_OFS, 8'hb0);
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		`CHK("fast pll off", 6'h22, {dig, pll, dac, clk_pd, ext, full})
		// Unmapped and status writes are ignored, unmapped reads give 0
		@(posedge i_clk_sys);
		wr(4'h2, 8'h00);
		@(posedge i_clk_sys);
		wr(pdc_pkg::STAT_OFS, 8'h00);
		rd(pdc_pkg::CTRL_OFS, got);
		`CHK("ctrl kept", 8'hb0, got)
		rd(4'h2, got);
		`CHK("unmapped", 8'h00, got)
		@(negedge i_clk_sys);
		`CHK("rd idle", 8'h00, rd_data)
		// Reset in mid-run returns every domain to active
		ctl_u.set_pin(1'b0);
		repeat (4) @(posedge i_clk_sys);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		rd(pdc_pkg::CTRL_OFS, got);
		`CHK("ctrl re-reset", 8'h00, got)
		`CHK("outs re-reset", 6'h00, {dig, pll, dac, clk_pd, ext, full})
		summarize();
	end

	// Whole run takes about 1,100 cycles; cut off at 10,000
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
endmodule
